// file: core/ccu_regs.vh
// Register map, field positions and reset values of the capture/compare unit.
`ifndef CCU_REGS_VH
`define CCU_REGS_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define CCU_OFS_CTRL 8'h00
`define CCU_OFS_TIMER_A 8'h04
`define CCU_OFS_TIMER_B 8'h08
`define CCU_OFS_RELOAD_A 8'h0c
`define CCU_OFS_RELOAD_B 8'h10
`define CCU_OFS_STATUS 8'h14
`define CCU_OFS_MASK 8'h18
`define CCU_OFS_PINS 8'h1c
`define CCU_OFS_VAL_BASE 8'h40
`define CCU_OFS_CFG_BASE 8'h80

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define CCU_CTRL_RUN_A 0
`define CCU_CTRL_RUN_B 1
`define CCU_CTRL_SRC_A 3:2
`define CCU_CTRL_SRC_B 5:4
`define CCU_CTRL_PRE_A 8:6
`define CCU_CTRL_PRE_B 11:9
`define CCU_CTRL_STAGGER 12
`define CCU_CTRL_W 13
`define CCU_CTRL_RST 13'h0000

// Clock source codes of a time-base timer.
`define CCU_SRC_PRESCALED 2'h0
`define CCU_SRC_GEN_OVF 2'h1
`define CCU_SRC_EXT_COUNT 2'h2
`define CCU_SRC_HALT 2'h3

// Least prescaler exponent in staggered operation (one step per eight cycles).
`define CCU_STAGGER_EXP 3'h3

// ----------------------------------------------------------------------------
// Per-channel configuration fields
// ----------------------------------------------------------------------------
`define CCU_CFG_EN 0
`define CCU_CFG_TSEL 1
`define CCU_CFG_CAPTURE 2
`define CCU_CFG_MODE 4:3
`define CCU_CFG_EDGE 6:5
`define CCU_CFG_RISE 5
`define CCU_CFG_FALL 6
`define CCU_CFG_SINGLE 7
`define CCU_CFG_DOUBLE 8
`define CCU_CFG_W 9
`define CCU_CFG_RST 9'h000

`define CCU_MODE_IRQ_MULTI 2'h0
`define CCU_MODE_TOGGLE 2'h1
`define CCU_MODE_IRQ_ONCE 2'h2
`define CCU_MODE_SET_CLR 2'h3

// Status and mask: bits 15:0 channels, 16 timer A overflow, 17 timer B overflow.
`define CCU_ST_OVF_A 16
`define CCU_ST_OVF_B 17
`define CCU_ST_W 18

`define CCU_RESP_OKAY 2'h0
`define CCU_RESP_SLVERR 2'h2

`endif

// file: core/ccu_capture_compare.v
// Capture/compare unit: two reloadable time-base timers, sixteen channels, AXI4-Lite registers.
//
// Contract
// - Sixteen channels; one-cycle resolution, eight cycles when staggered.
// - Two independent 16-bit time-base timers, each with a reload register.
// - Each timer clock selectable among prescaled system clock versions.
// - Timer may advance on each external general timer overflow/underflow event.
// - Timer A also accepts an external count input.
// - Sixteen registers, each assignable to either timer, capture or compare.
// - Each register uses its pin as capture input or compare output.
// - Mode zero: interrupt only on match, several per period.
// - Mode one: pin toggles on every match, several per period.
// - Mode two: interrupt only, at most once per timer period.
// - Mode three: pin set on match, cleared on timer overflow, once per period.
// - Double-register: two registers share one pin, toggling on either match.
// - Single-event option yields one edge or pulse with any compare mode; here the first compare event clears the enable and o_pin_oe at once.
// - Capture latches allocated timer value on the selected pin event.
// - Each capture raises that register's own interrupt request.
// - Capture edge selectable: rising, falling or both.
// - Compare registers compared continuously; equality triggers mode action; here only a timer step to the compare value triggers it.
`timescale 1ns/1ps
`include "ccu_regs.vh"

module ccu_capture_compare #(
  parameter NUM_CH = 16,
  parameter TW = 16
) (
  // Clock and reset
  input wire i_clk,
  input wire i_sys_rst,
  // AXI4-Lite write address and data
  input wire i_axi_awvalid,
  output wire o_axi_awready,
  input wire [7:0] i_axi_awaddr,
  input wire i_axi_wvalid,
  output wire o_axi_wready,
  input wire [31:0] i_axi_wdata,
  input wire [3:0] i_axi_wstrb,
  // AXI4-Lite write response
  output reg o_axi_bvalid,
  input wire i_axi_bready,
  output reg [1:0] o_axi_bresp,
  // AXI4-Lite read
  input wire i_axi_arvalid,
  output wire o_axi_arready,
  input wire [7:0] i_axi_araddr,
  output reg o_axi_rvalid,
  input wire i_axi_rready,
  output reg [31:0] o_axi_rdata,
  output reg [1:0] o_axi_rresp,
  // Event inputs
  input wire i_gen_timer_ovf,
  input wire i_ext_count,
  // Channel pins
  input wire [NUM_CH-1:0] i_pin,
  output reg [NUM_CH-1:0] o_pin,
  output wire [NUM_CH-1:0] o_pin_oe,
  // Interrupt
  output wire o_irq
);

  // --------------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------------
  function [31:0] apply_strb;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer b;
    begin
      apply_strb = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          apply_strb[b*8 +: 8] = nw[b*8 +: 8];
        end
      end
    end
  endfunction

  // True when the free prescaler reaches the end of a 2^exp period.
  function presc_tick;
    input [7:0] cnt;
    input [2:0] exp;
    input stag;
    reg [2:0] e;
    reg [7:0] m;
    begin
      e = (stag && exp < `CCU_STAGGER_EXP) ? `CCU_STAGGER_EXP : exp;
      m = (8'h01 << e) - 8'h01;
      presc_tick = ((cnt & m) == m);
    end
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  reg [`CCU_CTRL_W-1:0] ctrl;
  reg [TW-1:0] timer_a;
  reg [TW-1:0] timer_b;
  reg [TW-1:0] reload_a;
  reg [TW-1:0] reload_b;
  reg [`CCU_ST_W-1:0] status;
  reg [`CCU_ST_W-1:0] mask;
  reg [TW-1:0] cc_val [0:NUM_CH-1];
  reg [`CCU_CFG_W-1:0] cc_cfg [0:NUM_CH-1];
  reg [NUM_CH-1:0] done;
  reg [NUM_CH-1:0] pin_prev;
  reg [7:0] presc;
  reg ext_prev;

  // --------------------------------------------------------------------------
  // Time-base timers
  // --------------------------------------------------------------------------
  reg tick_a;
  reg tick_b;
  wire ext_rise = i_ext_count & ~ext_prev;
  wire ovf_a = tick_a & (timer_a == {TW{1'b1}});
  wire ovf_b = tick_b & (timer_b == {TW{1'b1}});
  wire [TW-1:0] next_timer_a = ovf_a ? reload_a : timer_a + {{(TW-1){1'b0}}, 1'b1};
  wire [TW-1:0] next_timer_b = ovf_b ? reload_b : timer_b + {{(TW-1){1'b0}}, 1'b1};

  always @* begin
    tick_a = 1'b0;
    tick_b = 1'b0;
    case (ctrl[`CCU_CTRL_SRC_A])
      `CCU_SRC_PRESCALED: tick_a = presc_tick(presc, ctrl[`CCU_CTRL_PRE_A], ctrl[`CCU_CTRL_STAGGER]);
      `CCU_SRC_GEN_OVF: tick_a = i_gen_timer_ovf;
      `CCU_SRC_EXT_COUNT: tick_a = ext_rise;
      default: tick_a = 1'b0;
    endcase
    case (ctrl[`CCU_CTRL_SRC_B])
      `CCU_SRC_PRESCALED: tick_b = presc_tick(presc, ctrl[`CCU_CTRL_PRE_B], ctrl[`CCU_CTRL_STAGGER]);
      `CCU_SRC_GEN_OVF: tick_b = i_gen_timer_ovf;
      default: tick_b = 1'b0;
    endcase
    tick_a = tick_a & ctrl[`CCU_CTRL_RUN_A];
    tick_b = tick_b & ctrl[`CCU_CTRL_RUN_B];
  end

  // --------------------------------------------------------------------------
  // Channel events
  // --------------------------------------------------------------------------
  // A compare match is judged on the value the timer steps to, so that a
  // stopped timer holding a matching value does not fire every cycle.
  reg [NUM_CH-1:0] match;
  reg [NUM_CH-1:0] cap_ev;
  reg [NUM_CH-1:0] ch_ovf;
  reg [NUM_CH-1:0] fire;
  integer c;
  always @* begin
    match = {NUM_CH{1'b0}};
    cap_ev = {NUM_CH{1'b0}};
    ch_ovf = {NUM_CH{1'b0}};
    fire = {NUM_CH{1'b0}};
    for (c = 0; c < NUM_CH; c = c + 1) begin
      ch_ovf[c] = cc_cfg[c][`CCU_CFG_TSEL] ? ovf_b : ovf_a;
      if (cc_cfg[c][`CCU_CFG_EN] && !cc_cfg[c][`CCU_CFG_CAPTURE]) begin
        match[c] = cc_cfg[c][`CCU_CFG_TSEL] ? (tick_b && next_timer_b == cc_val[c]) :
                   (tick_a && next_timer_a == cc_val[c]);
        fire[c] = match[c] && !(cc_cfg[c][`CCU_CFG_MODE] == `CCU_MODE_IRQ_ONCE && done[c]) &&
                  !(cc_cfg[c][`CCU_CFG_MODE] == `CCU_MODE_SET_CLR && done[c]);
      end
      if (cc_cfg[c][`CCU_CFG_EN] && cc_cfg[c][`CCU_CFG_CAPTURE]) begin
        cap_ev[c] = (cc_cfg[c][`CCU_CFG_RISE] && i_pin[c] && !pin_prev[c]) ||
                    (cc_cfg[c][`CCU_CFG_FALL] && !i_pin[c] && pin_prev[c]);
      end
    end
  end

  // Pin drive: enabled compare channels own their pin.
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g = g + 1) begin : g_oe
      assign o_pin_oe[g] = cc_cfg[g][`CCU_CFG_EN] & ~cc_cfg[g][`CCU_CFG_CAPTURE];
    end
  endgenerate

  // --------------------------------------------------------------------------
  // AXI4-Lite slave
  // --------------------------------------------------------------------------
  // Address and data are taken together in one cycle; the response follows next.
  wire wr_go = i_axi_awvalid & i_axi_wvalid & ~o_axi_bvalid;
  wire rd_go = i_axi_arvalid & ~o_axi_rvalid;
  assign o_axi_awready = wr_go;
  assign o_axi_wready = wr_go;
  assign o_axi_arready = rd_go;

  wire [5:0] waddr_w = i_axi_awaddr[7:2];
  wire [5:0] raddr_w = i_axi_araddr[7:2];
  wire wr_val = wr_go && i_axi_awaddr[7:6] == 2'h1;
  wire wr_cfg = wr_go && i_axi_awaddr[7:6] == 2'h2;
  wire [3:0] wch = waddr_w[3:0];
  wire wr_ctrl = wr_go && i_axi_awaddr[7:2] == `CCU_OFS_CTRL >> 2;
  wire wr_ta = wr_go && i_axi_awaddr[7:2] == `CCU_OFS_TIMER_A >> 2;
  wire wr_tb = wr_go && i_axi_awaddr[7:2] == `CCU_OFS_TIMER_B >> 2;
  wire wr_ra = wr_go && i_axi_awaddr[7:2] == `CCU_OFS_RELOAD_A >> 2;
  wire wr_rb = wr_go && i_axi_awaddr[7:2] == `CCU_OFS_RELOAD_B >> 2;
  wire wr_st = wr_go && i_axi_awaddr[7:2] == `CCU_OFS_STATUS >> 2;
  wire wr_mk = wr_go && i_axi_awaddr[7:2] == `CCU_OFS_MASK >> 2;
  wire wr_hit = wr_ctrl | wr_ta | wr_tb | wr_ra | wr_rb | wr_st | wr_mk | wr_val | wr_cfg |
                (wr_go && i_axi_awaddr[7:2] == `CCU_OFS_PINS >> 2);
  wire [31:0] st_clr = apply_strb(32'h0, i_axi_wdata, i_axi_wstrb);

  reg [31:0] rd_word;
  reg rd_hit;
  always @* begin
    rd_hit = 1'b1;
    rd_word = 32'h0;
    if (i_axi_araddr[7:6] == 2'h1) begin
      rd_word[TW-1:0] = cc_val[raddr_w[3:0]];
    end else if (i_axi_araddr[7:6] == 2'h2) begin
      rd_word[`CCU_CFG_W-1:0] = cc_cfg[raddr_w[3:0]];
    end else begin
      case (i_axi_araddr[7:0] & 8'hfc)
        `CCU_OFS_CTRL: rd_word[`CCU_CTRL_W-1:0] = ctrl;
        `CCU_OFS_TIMER_A: rd_word[TW-1:0] = timer_a;
        `CCU_OFS_TIMER_B: rd_word[TW-1:0] = timer_b;
        `CCU_OFS_RELOAD_A: rd_word[TW-1:0] = reload_a;
        `CCU_OFS_RELOAD_B: rd_word[TW-1:0] = reload_b;
        `CCU_OFS_STATUS: rd_word[`CCU_ST_W-1:0] = status;
        `CCU_OFS_MASK: rd_word[`CCU_ST_W-1:0] = mask;
        `CCU_OFS_PINS: rd_word = {i_pin, o_pin};
        default: rd_hit = 1'b0;
      endcase
    end
  end

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_axi_bvalid <= 1'b0;
      o_axi_bresp <= `CCU_RESP_OKAY;
      o_axi_rvalid <= 1'b0;
      o_axi_rdata <= 32'h0;
      o_axi_rresp <= `CCU_RESP_OKAY;
    end else begin
      if (wr_go) begin
        o_axi_bvalid <= 1'b1;
        o_axi_bresp <= wr_hit ? `CCU_RESP_OKAY : `CCU_RESP_SLVERR;
      end else if (i_axi_bready) begin
        o_axi_bvalid <= 1'b0;
      end
      if (rd_go) begin
        o_axi_rvalid <= 1'b1;
        o_axi_rdata <= rd_word;
        o_axi_rresp <= rd_hit ? `CCU_RESP_OKAY : `CCU_RESP_SLVERR;
      end else if (i_axi_rready) begin
        o_axi_rvalid <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Timers, control and interrupt status
  // --------------------------------------------------------------------------
  // A software write to a timer wins over its count step in the same cycle.
  wire [31:0] ta_w = apply_strb({16'h0, timer_a}, i_axi_wdata, i_axi_wstrb);
  wire [31:0] tb_w = apply_strb({16'h0, timer_b}, i_axi_wdata, i_axi_wstrb);
  wire [31:0] ra_w = apply_strb({16'h0, reload_a}, i_axi_wdata, i_axi_wstrb);
  wire [31:0] rb_w = apply_strb({16'h0, reload_b}, i_axi_wdata, i_axi_wstrb);
  wire [31:0] ct_w = apply_strb({19'h0, ctrl}, i_axi_wdata, i_axi_wstrb);
  wire [31:0] mk_w = apply_strb({14'h0, mask}, i_axi_wdata, i_axi_wstrb);
  // Byte-lane merge for a channel value write; a capture in the same cycle wins.
  wire [31:0] val_w = apply_strb({16'h0, cc_val[wch]}, i_axi_wdata, i_axi_wstrb);
  wire [`CCU_ST_W-1:0] st_set = {ovf_b, ovf_a, fire | cap_ev};

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      ctrl <= `CCU_CTRL_RST;
      timer_a <= 16'h0000;
      timer_b <= 16'h0000;
      reload_a <= 16'h0000;
      reload_b <= 16'h0000;
      status <= 18'h00000;
      mask <= 18'h00000;
      presc <= 8'h00;
      ext_prev <= 1'b0;
      pin_prev <= {NUM_CH{1'b0}};
    end else begin
      presc <= presc + 8'h01;
      ext_prev <= i_ext_count;
      pin_prev <= i_pin;
      if (wr_ctrl) begin
        ctrl <= ct_w[`CCU_CTRL_W-1:0];
      end
      if (wr_ta) begin
        timer_a <= ta_w[TW-1:0];
      end else if (tick_a) begin
        timer_a <= next_timer_a;
      end
      if (wr_tb) begin
        timer_b <= tb_w[TW-1:0];
      end else if (tick_b) begin
        timer_b <= next_timer_b;
      end
      if (wr_ra) begin
        reload_a <= ra_w[TW-1:0];
      end
      if (wr_rb) begin
        reload_b <= rb_w[TW-1:0];
      end
      if (wr_mk) begin
        mask <= mk_w[`CCU_ST_W-1:0];
      end
      // A new event in the clearing cycle keeps its bit set.
      status <= (status & ~(wr_st ? st_clr[`CCU_ST_W-1:0] : {`CCU_ST_W{1'b0}})) | st_set;
    end
  end

  assign o_irq = |(status & mask);

  // --------------------------------------------------------------------------
  // Capture/compare channels
  // --------------------------------------------------------------------------
  reg [NUM_CH-1:0] next_pin;
  integer k;
  always @* begin
    next_pin = o_pin;
    for (k = 0; k < NUM_CH; k = k + 1) begin
      if (fire[k] && cc_cfg[k][`CCU_CFG_MODE] == `CCU_MODE_TOGGLE) begin
        next_pin[k] = ~next_pin[k];
      end
      // The upper partner only steers a pin that the lower channel drives.
      if (k < NUM_CH / 2 && cc_cfg[k][`CCU_CFG_DOUBLE] && o_pin_oe[k] &&
          fire[k + NUM_CH / 2]) begin
        next_pin[k] = ~next_pin[k];
      end
      if (cc_cfg[k][`CCU_CFG_EN] && !cc_cfg[k][`CCU_CFG_CAPTURE] &&
          cc_cfg[k][`CCU_CFG_MODE] == `CCU_MODE_SET_CLR) begin
        if (fire[k]) begin
          next_pin[k] = 1'b1;
        end else if (ch_ovf[k]) begin
          next_pin[k] = 1'b0;
        end
      end
    end
  end

  // Mode zero leaves the pin alone; only the status bit records the match.
  integer j;
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_pin <= {NUM_CH{1'b0}};
      done <= {NUM_CH{1'b0}};
      for (j = 0; j < NUM_CH; j = j + 1) begin
        cc_val[j] <= 16'h0000;
        cc_cfg[j] <= `CCU_CFG_RST;
      end
    end else begin
      o_pin <= next_pin;
      for (j = 0; j < NUM_CH; j = j + 1) begin
        if (fire[j]) begin
          done[j] <= 1'b1;
        end else if (ch_ovf[j]) begin
          done[j] <= 1'b0;
        end
        if (cap_ev[j]) begin
          cc_val[j] <= cc_cfg[j][`CCU_CFG_TSEL] ? timer_b : timer_a;
        end else if (wr_val && wch == j[3:0]) begin
          cc_val[j] <= val_w[TW-1:0];
        end
        if (wr_cfg && wch == j[3:0]) begin
          cc_cfg[j] <= i_axi_wdata[`CCU_CFG_W-1:0];
        end else if (fire[j] && cc_cfg[j][`CCU_CFG_SINGLE]) begin
          cc_cfg[j][`CCU_CFG_EN] <= 1'b0;
        end
      end
    end
  end

endmodule // ccu_capture_compare

// file: testbench/ccu_cc_monitor.sv
// Port-level checker for the capture/compare unit, bound to its top module.
`timescale 1ns/1ps
module ccu_cc_monitor #(parameter NUM_CH = 16) (
  // Clock and reset
  input wire i_clk,
  input wire i_sys_rst,
  // Register bus
  input wire i_axi_awvalid,
  input wire i_axi_wvalid,
  input wire o_axi_awready,
  input wire o_axi_wready,
  input wire o_axi_bvalid,
  input wire i_axi_bready,
  input wire i_axi_arvalid,
  input wire o_axi_arready,
  input wire o_axi_rvalid,
  input wire i_axi_rready,
  input wire [31:0] o_axi_rdata,
  input wire [1:0] o_axi_rresp,
  // Pins and interrupt
  input wire [NUM_CH-1:0] o_pin,
  input wire [NUM_CH-1:0] o_pin_oe,
  input wire o_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  AST_WR_READY: assert property (o_axi_awready |-> i_axi_awvalid && i_axi_wvalid && !o_axi_bvalid && o_axi_wready)
    else $error("write taken out of turn");
  AST_WR_RESP: assert property (i_axi_awvalid && o_axi_awready |=> o_axi_bvalid)
    else $error("write response late");
  AST_WR_DONE: assert property (o_axi_bvalid && i_axi_bready |=> !o_axi_bvalid)
    else $error("write response not released");
  AST_WR_SPUR: assert property (!(i_axi_awvalid && o_axi_awready) && !o_axi_bvalid |=> !o_axi_bvalid)
    else $error("write response without request");
  AST_RD_READY: assert property (o_axi_arready == (i_axi_arvalid && !o_axi_rvalid))
    else $error("read ready wrong");
  AST_RD_DONE: assert property (o_axi_rvalid && i_axi_rready |=> !o_axi_rvalid)
    else $error("read response not released");
  AST_RD_ERR: assert property (o_axi_rvalid && o_axi_rresp == 2'h2 |-> o_axi_rdata == 32'h0)
    else $error("error read carries data");
  AST_IRQ_FALL: assert property ($fell(o_irq) |-> $past(i_axi_awvalid && o_axi_awready) || $past(i_sys_rst))
    else $error("interrupt dropped without a write");
  AST_PIN_OE: assert property (((o_pin ^ $past(o_pin)) & ~o_pin_oe & ~$past(o_pin_oe)) == 0)
    else $error("pin moved while not driven");
  AST_RESET: assert property (disable iff (1'b0) i_sys_rst |=> o_pin == 0 && o_pin_oe == 0 && !o_irq)
    else $error("outputs not cleared by reset");
endmodule // ccu_cc_monitor

bind ccu_capture_compare ccu_cc_monitor #(.NUM_CH(NUM_CH)) u_mon (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_axi_awvalid(i_axi_awvalid), .i_axi_wvalid(i_axi_wvalid), .o_axi_awready(o_axi_awready),
  .o_axi_wready(o_axi_wready), .o_axi_bvalid(o_axi_bvalid), .i_axi_bready(i_axi_bready),
  .i_axi_arvalid(i_axi_arvalid), .o_axi_arready(o_axi_arready), .o_axi_rvalid(o_axi_rvalid),
  .i_axi_rready(i_axi_rready), .o_axi_rdata(o_axi_rdata), .o_axi_rresp(o_axi_rresp),
  .o_pin(o_pin), .o_pin_oe(o_pin_oe), .o_irq(o_irq));

// file: testbench/ccu_pin_board.sv
// Board model of the sixteen channel pins.
`timescale 1ns/1ps
module ccu_pin_board (
  // Board drive and unit outputs
  input wire [15:0] i_drive,
  input wire [15:0] i_out,
  input wire [15:0] i_oe,
  // Level seen on the pins
  output wire [15:0] o_level
);
  // A compare pin shows the unit's level, a capture pin the board's.
  assign o_level = (i_oe & i_out) | (~i_oe & i_drive);
endmodule // ccu_pin_board

// file: testbench/ccu_capture_compare_test.sv
// Self-checking testbench of the capture/compare unit.
`timescale 1ns/1ps
`include "ccu_regs.vh"
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin failures++; \
  $display("unexpected %s exp %0h got %0h", n, e, s); end end
module ccu_capture_compare_test;
  logic clk = 0, rst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, gov = 0, ext = 0;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd_v;
  logic [15:0] drv = 0, v, w;
  logic [1:0] resp;
  logic p1, p3, p5;
  wire awr, wrd, bv, arr, rv, irq;
  wire [1:0] br, rr;
  wire [31:0] rdt;
  wire [15:0] op, oe, pin;
  int failures = 0, comparisons = 0, i, k, t1, t3, t5;
  int cfg[5] = '{'h01, 'h09, 'h11, 'h19, 'h89};
  int ctl[3] = '{'h001, 'h081, 'h1001};
  int win[3] = '{64, 256, 512};
  ccu_capture_compare dut (.i_clk(clk), .i_sys_rst(rst), .i_axi_awvalid(awv), .o_axi_awready(awr),
    .i_axi_awaddr(awa), .i_axi_wvalid(wv), .o_axi_wready(wrd), .i_axi_wdata(wd), .i_axi_wstrb(4'hf),
    .o_axi_bvalid(bv), .i_axi_bready(bre), .o_axi_bresp(br), .i_axi_arvalid(arv), .o_axi_arready(arr),
    .i_axi_araddr(ara), .o_axi_rvalid(rv), .i_axi_rready(rre), .o_axi_rdata(rdt), .o_axi_rresp(rr),
    .i_gen_timer_ovf(gov), .i_ext_count(ext), .i_pin(pin), .o_pin(op), .o_pin_oe(oe), .o_irq(irq));
  ccu_pin_board board (.i_drive(drv), .i_out(op), .i_oe(oe), .o_level(pin));
  always #25 clk = ~clk;
  task final_report;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task wt(input int n);
    if (n >= 50) begin
      failures++;
      $display("unexpected bus wait exp answer got timeout");
      final_report;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    int n;
    @(posedge clk);
    awa <= a; wd <= d; awv <= 1; wv <= 1; bre <= 1; n = 0;
    do begin @(posedge clk); n++; end while (awr !== 1 && n < 50);
    awv <= 0; wv <= 0;
    while (bv !== 1 && n < 50) begin @(posedge clk); n++; end
    bre <= 0; resp = br; wt(n);
  endtask
  task rd(input [7:0] a);
    int n;
    @(posedge clk);
    ara <= a; arv <= 1; rre <= 1; n = 0;
    do begin @(posedge clk); n++; end while (arr !== 1 && n < 50);
    arv <= 0;
    while (rv !== 1 && n < 50) begin @(posedge clk); n++; end
    rre <= 0; rd_v = rdt; resp = rr; wt(n);
  endtask
  task pin_set(input int b, input logic l);
    @(posedge clk);
    drv[b] <= l;
    tick(3);
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    $display("unexpected run length exp done got timeout");
    final_report;
  end
  initial begin
    v = $urandom(236);
    repeat (5) @(posedge clk);
    rst <= 0;
    rd(`CCU_OFS_STATUS); `CHK("status reset", 0, rd_v)
    rd(8'h20); `CHK("unmapped read", 34'h200000000, {resp, rd_v})
    wr(8'h20, 1); `CHK("unmapped write", 2, resp)
    // --------------------------------------------------------------------
    // Event clocking, then compare modes at three tick rates.
    // --------------------------------------------------------------------
    v = $urandom & 'h7fff;
    wr(`CCU_OFS_CTRL, 'h5); wr(`CCU_OFS_TIMER_A, v);
    repeat (5) begin tick(1); gov <= 1; tick(1); gov <= 0; end
    wr(`CCU_OFS_CTRL, 'h9);
    repeat (3) begin tick(1); ext <= 1; tick(2); ext <= 0; tick(1); end
    wr(`CCU_OFS_CTRL, 0); rd(`CCU_OFS_TIMER_A);
    `CHK("event count", v + 16'd8, rd_v[15:0])
    wr(`CCU_OFS_RELOAD_A, 'hfff0); wr(`CCU_OFS_TIMER_A, 'hfff0);
    for (i = 0; i < 5; i++) begin
      wr(8'('h40 + 4 * i), 'hfff8); wr(8'('h80 + 4 * i), cfg[i]);
    end
    wr(8'h54, 'hfff2); wr(8'h94, 'h109); wr(8'h74, 'hfffc); wr(8'hb4, 'h01);
    for (k = 0; k < 3; k++) begin
      wr(`CCU_OFS_CTRL, ctl[k]); tick(300);
      t1 = 0; t3 = 0; t5 = 0; p1 = op[1]; p3 = op[3]; p5 = op[5];
      repeat (win[k]) begin
        @(posedge clk);
        if (op[1] !== p1) t1++;
        if (op[5] !== p5) t5++;
        if (op[3] === 1 && p3 === 0) t3++;
        p1 = op[1]; p3 = op[3]; p5 = op[5];
      end
      `CHK("toggles", 4, t1)
      `CHK("double toggles", 8, t5)
      `CHK("set pulses", 4, t3)
    end
    `CHK("compare drive", 4'hf, oe[3:0])
    `CHK("single pin", 1'b1, op[4])
    wr(`CCU_OFS_CTRL, 0); rd(`CCU_OFS_STATUS);
    `CHK("compare flags", 'h10005, rd_v & 'h10005)
    rd(`CCU_OFS_TIMER_A); `CHK("reload range", 1'b1, rd_v >= 'hfff0)
    rd(8'h90); `CHK("single enable", 1'b0, rd_v[0])
    // Stepped timers: overflow, then two matches in one period.
    wr(`CCU_OFS_CTRL, 'h17); wr(`CCU_OFS_TIMER_B, v); wr(`CCU_OFS_TIMER_A, 'hffff);
    for (i = 0; i < 3; i++) begin
      tick(1); gov <= 1; tick(1); gov <= 0;
      if (i < 2) begin
        wr(`CCU_OFS_STATUS, 'h3ffff); wr(`CCU_OFS_TIMER_A, 'hfff7);
      end
    end
    rd(`CCU_OFS_STATUS); `CHK("once per period", 'h1, rd_v & 'h5)
    rd(`CCU_OFS_TIMER_B); `CHK("timer b count", v + 16'd3, rd_v[15:0])
    wr(`CCU_OFS_CTRL, 0);
    wr(`CCU_OFS_STATUS, 'h3ffff); rd(`CCU_OFS_STATUS); `CHK("w1c", 0, rd_v)
    // --------------------------------------------------------------------
    // Capture on both timers with edge selection and interrupt.
    // --------------------------------------------------------------------
    v = $urandom; w = $urandom;
    wr(`CCU_OFS_TIMER_A, v); wr(`CCU_OFS_TIMER_B, w); wr(`CCU_OFS_MASK, 'h300);
    wr(8'ha0, 'h25); wr(8'ha4, 'h67);
    `CHK("irq idle", 1'b0, irq)
    pin_set(8, 1); pin_set(9, 1);
    rd(8'h60); `CHK("capture a", v, rd_v[15:0])
    rd(8'h64); `CHK("capture b", w, rd_v[15:0])
    `CHK("irq set", 1'b1, irq)
    rd(`CCU_OFS_STATUS); `CHK("capture flags", 'h300, rd_v)
    wr(`CCU_OFS_TIMER_A, v ^ 16'h5555); wr(`CCU_OFS_TIMER_B, w ^ 16'haaaa);
    pin_set(8, 0); pin_set(9, 0);
    rd(8'h60); `CHK("no fall capture", v, rd_v[15:0])
    rd(8'h64); `CHK("fall capture", w ^ 16'haaaa, rd_v[15:0])
    wr(`CCU_OFS_STATUS, 'h300); `CHK("irq clear", 1'b0, irq)
    final_report;
  end
endmodule // ccu_capture_compare_test
